// >>> adc_ctrl_pkg.sv
// Package of register map, field positions and states for the converter control block
package adc_ctrl_pkg;
  localparam logic [7:0] POWER_CFG_OFFSET = 8'h00;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] EVENT_STATUS_OFFSET = 8'hE0;
  localparam logic [7:0] EVENT_MASK_OFFSET = 8'hE4;
  localparam logic [7:0] SEQ_STATUS_OFFSET = 8'hE8;

  // Power and configuration word fields
  localparam int MASTER_EN_BIT = 0;
  localparam int GAIN_AMP_EN_BIT = 1;
  localparam int MODULATOR_EN_BIT = 2;
  localparam int ANTIALIAS_EN_BIT = 3;
  localparam int SINC_CLK_EN_BIT = 4;
  localparam int POS_REF_EN_BIT = 5;
  localparam int CURRENT_REF_EN_BIT = 7;
  localparam int BIAS_GEN_EN_BIT = 9;
  localparam int PHASE_CLK_EN_BIT = 10;
  localparam int ONE_SWEEP_BIT = 13;
  localparam int START_DELAY_LSB = 14;
  localparam int COMBINED_IRQ_EN_BIT = 24;
  localparam int SOURCE_IEN_LSB = 27;
  localparam logic [31:0] POWER_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] POWER_CFG_WMASK = 32'hF900_E6BF;

  // Command word fields
  localparam int TRIGGER_BIT = 0;
  localparam int STOP_CONT_BIT = 7;
  localparam int SHORT_WRAP_BIT = 8;
  localparam int READY_FLAG_BIT = 9;
  localparam int RESTORE_BIT = 31;
  localparam logic SHORT_WRAP_RESET = 1'b0;

  // Event bits: five converter sources, then sweep halted
  localparam int NUM_EVENTS = 6;
  localparam int NUM_SOURCES = 5;
  localparam int SWEEP_HALT_BIT = 5;
  localparam logic [NUM_EVENTS-1:0] EVENT_RESET = 6'h00;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;
endpackage

// >>> adc_power_and_command_control.sv
// Power-down, clock gating, command and sequencer control of the converter, APB slave
`timescale 1ns/1ps
module adc_power_and_command_control
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic anyChannelEnabled,
  input wire logic sweepDone,
  input wire logic [adc_ctrl_pkg::NUM_SOURCES-1:0] sourceEvent,
  output logic phaseClkGenPowerDown,
  output logic biasGenPowerDown,
  output logic currentRefPowerDown,
  output logic posRefBufPowerDown,
  output logic antialiasPowerDown,
  output logic modulatorPowerDown,
  output logic gainAmpPowerDown,
  output logic sincClkEnable,
  output logic cubicClkEnable,
  output logic moduleClkEnable,
  output logic analogReset,
  output logic [1:0] startDelay,
  output logic sweepStart,
  output logic shortWrapDelay,
  output logic restoreDefaults,
  output logic sequencerBusy,
  output logic combinedIrq,
  output logic irq
);
  import adc_ctrl_pkg::*;

  logic [31:0] powerCfg_r;
  logic shortWrap_r;
  logic [NUM_EVENTS-1:0] eventStatus_r;
  logic [NUM_EVENTS-1:0] eventMask_r;
  logic stopPending_r;
  logic readyFlag_r;
  seq_state_t seqState_r;
  logic accessDone;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic cmdTrigger;
  logic cmdStop;
  logic cmdRestore;
  logic sweepHalt;
  logic [NUM_EVENTS-1:0] eventIn;
  logic [31:0] readWord;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction

  // One wait state keeps pready and prdata registered
  assign accessDone = psel && penable && pready;
  assign wrEn = accessDone && pwrite && clkEn;
  assign rdEn = accessDone && !pwrite && clkEn;
  assign mapped = hit(paddr, POWER_CFG_OFFSET) || hit(paddr, COMMAND_OFFSET)
    || hit(paddr, EVENT_STATUS_OFFSET) || hit(paddr, EVENT_MASK_OFFSET)
    || hit(paddr, SEQ_STATUS_OFFSET);

  // Single write of one issues a command; zero does nothing
  assign cmdTrigger = wrEn && hit(paddr, COMMAND_OFFSET) && pwdata[TRIGGER_BIT];
  assign cmdStop = wrEn && hit(paddr, COMMAND_OFFSET) && pwdata[STOP_CONT_BIT];
  assign cmdRestore = wrEn && hit(paddr, COMMAND_OFFSET) && pwdata[RESTORE_BIT];

  // Sweep ends and sequencer stops rather than wrapping
  assign sweepHalt = (seqState_r == SEQ_RUN) && sweepDone
    && (powerCfg_r[ONE_SWEEP_BIT] || stopPending_r || cmdStop);
  assign eventIn = {sweepHalt, sourceEvent};

  always_comb
  begin
    readWord = 32'h0000_0000;
    if (hit(paddr, POWER_CFG_OFFSET))
    begin
      readWord = powerCfg_r;
    end
    else if (hit(paddr, COMMAND_OFFSET))
    begin
      // Command bits always read back zero
      readWord[READY_FLAG_BIT] = readyFlag_r;
      readWord[SHORT_WRAP_BIT] = shortWrap_r;
    end
    else if (hit(paddr, EVENT_STATUS_OFFSET))
    begin
      readWord[NUM_EVENTS-1:0] = eventStatus_r;
    end
    else if (hit(paddr, EVENT_MASK_OFFSET))
    begin
      readWord[NUM_EVENTS-1:0] = eventMask_r;
    end
    else if (hit(paddr, SEQ_STATUS_OFFSET))
    begin
      readWord[0] = seqState_r == SEQ_RUN;
      readWord[1] = stopPending_r;
    end
  end

  // Low clock enable also holds pready; keep it high during a transfer
  // or the master may see a stale pready while the write is dropped
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : readWord;
        pslverr <= !mapped;
      end
      else
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration register; restore command returns it to defaults
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      powerCfg_r <= POWER_CFG_RESET;
    end
    else if (wrEn && hit(paddr, POWER_CFG_OFFSET))
    begin
      powerCfg_r <= pwdata & POWER_CFG_WMASK;
    end
  end

  // Bit 8 is a stored setting; other command bits are not stored
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      shortWrap_r <= SHORT_WRAP_RESET;
    end
    else if (wrEn && hit(paddr, COMMAND_OFFSET))
    begin
      shortWrap_r <= pwdata[SHORT_WRAP_BIT];
    end
  end

  // Ready flag is hardware state; writes never reach it
  // Master enable not needed, so setup can be checked before power-up
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      readyFlag_r <= 1'b0;
    end
    else if (clkEn)
    begin
      readyFlag_r <= powerCfg_r[MODULATOR_EN_BIT] && anyChannelEnabled;
    end
  end

  // Sticky events: new event wins over the read clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      eventStatus_r <= EVENT_RESET;
    end
    else if (clkEn)
    begin
      if (rdEn && hit(paddr, EVENT_STATUS_OFFSET))
      begin
        eventStatus_r <= eventIn;
      end
      else
      begin
        eventStatus_r <= eventStatus_r | eventIn;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      eventMask_r <= EVENT_RESET;
    end
    else if (wrEn && hit(paddr, EVENT_MASK_OFFSET))
    begin
      eventMask_r <= pwdata[NUM_EVENTS-1:0];
    end
  end

  // Source enables gate only the combined interrupt line, never the status
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
      combinedIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      irq <= |(eventStatus_r & eventMask_r);
      combinedIrq <= powerCfg_r[COMBINED_IRQ_EN_BIT]
        && |(eventStatus_r[NUM_SOURCES-1:0]
        & powerCfg_r[SOURCE_IEN_LSB +: NUM_SOURCES]);
    end
  end

  // Stop request lives until the running sweep finishes
  // A stop while idle is dropped; there is no sweep to end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      stopPending_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (seqState_r != SEQ_RUN || sweepHalt)
      begin
        stopPending_r <= 1'b0;
      end
      else if (cmdStop)
      begin
        stopPending_r <= 1'b1;
      end
    end
  end

  // Trigger while running is ignored; master disable aborts the sequence
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && cmdRestore))
    begin
      seqState_r <= SEQ_IDLE;
      sweepStart <= 1'b0;
    end
    else if (clkEn)
    begin
      sweepStart <= 1'b0;
      if (!powerCfg_r[MASTER_EN_BIT])
      begin
        seqState_r <= SEQ_IDLE;
      end
      else
      begin
        unique case (seqState_r)
          SEQ_IDLE:
          begin
            if (cmdTrigger)
            begin
              seqState_r <= SEQ_RUN;
              sweepStart <= 1'b1;
            end
          end
          SEQ_RUN:
          begin
            if (sweepHalt)
            begin
              seqState_r <= SEQ_IDLE;
            end
            else if (sweepDone)
            begin
              sweepStart <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      restoreDefaults <= 1'b0;
      sequencerBusy <= 1'b0;
      shortWrapDelay <= 1'b0;
    end
    else if (clkEn)
    begin
      restoreDefaults <= cmdRestore;
      sequencerBusy <= seqState_r == SEQ_RUN;
      // Known to corrupt the first channel after a wrap; keep it clear
      shortWrapDelay <= shortWrap_r && seqState_r == SEQ_RUN;
    end
  end

  // Analog power-downs, all forced while the master enable is low
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      phaseClkGenPowerDown <= 1'b1;
      biasGenPowerDown <= 1'b1;
      currentRefPowerDown <= 1'b1;
      posRefBufPowerDown <= 1'b1;
      antialiasPowerDown <= 1'b1;
      modulatorPowerDown <= 1'b1;
      gainAmpPowerDown <= 1'b1;
      analogReset <= 1'b1;
    end
    else if (clkEn)
    begin
      phaseClkGenPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[PHASE_CLK_EN_BIT]);
      biasGenPowerDown <= !(powerCfg_r[MASTER_EN_BIT] && powerCfg_r[BIAS_GEN_EN_BIT]);
      currentRefPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[CURRENT_REF_EN_BIT]);
      posRefBufPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[POS_REF_EN_BIT]);
      antialiasPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[ANTIALIAS_EN_BIT]);
      gainAmpPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[GAIN_AMP_EN_BIT]);
      modulatorPowerDown <= !(powerCfg_r[MASTER_EN_BIT]
        && powerCfg_r[MODULATOR_EN_BIT]);
      analogReset <= !powerCfg_r[MASTER_EN_BIT];
    end
  end

  // Cubic and module clocks follow only the master enable so test data can pass; sinc clock also needs its enable bit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sincClkEnable <= 1'b0;
      cubicClkEnable <= 1'b0;
      moduleClkEnable <= 1'b0;
      startDelay <= 2'h0;
    end
    else if (clkEn)
    begin
      sincClkEnable <= powerCfg_r[MASTER_EN_BIT] && powerCfg_r[SINC_CLK_EN_BIT];
      cubicClkEnable <= powerCfg_r[MASTER_EN_BIT];
      moduleClkEnable <= powerCfg_r[MASTER_EN_BIT];
      startDelay <= powerCfg_r[START_DELAY_LSB +: 2];
    end
  end
endmodule

// >>> adc_ctrl_assertions.sv
// Checker of bus timing, power and pulse outputs of the converter control
`timescale 1ns/1ps
module adc_ctrl_checker
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phaseClkGenPowerDown,
  input wire logic biasGenPowerDown,
  input wire logic currentRefPowerDown,
  input wire logic posRefBufPowerDown,
  input wire logic antialiasPowerDown,
  input wire logic modulatorPowerDown,
  input wire logic gainAmpPowerDown,
  input wire logic sincClkEnable,
  input wire logic cubicClkEnable,
  input wire logic moduleClkEnable,
  input wire logic analogReset,
  input wire logic restoreDefaults,
  input wire logic sequencerBusy
);
  logic allDown;
  assign allDown = phaseClkGenPowerDown && biasGenPowerDown && currentRefPowerDown &&
    posRefBufPowerDown && antialiasPowerDown && modulatorPowerDown && gainAmpPowerDown;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable && clkEn;
  endsequence
  sequence s_access;
    psel && penable && clkEn;
  endsequence
  property p_one_wait;
    s_setup ##1 s_access |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_master_off;
    analogReset |-> allDown && !sincClkEnable && !cubicClkEnable && !moduleClkEnable;
  endproperty
  a_master_off: assert property (p_master_off) else $error("circuit alive in reset");
  property p_sinc_on;
    sincClkEnable |-> !analogReset;
  endproperty
  a_sinc_on: assert property (p_sinc_on) else $error("sinc clock with master off");
  property p_restore_pulse;
    restoreDefaults |=> !restoreDefaults;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse) else $error("restore not a pulse");
  property p_idle_master;
    analogReset [*2] |-> !sequencerBusy;
  endproperty
  a_idle_master: assert property (p_idle_master) else $error("busy with master off");
  property p_reset_state;
    $fell(sys_rst) |-> analogReset && allDown && !pready;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule
bind adc_power_and_command_control adc_ctrl_checker u_chk (.*);

// >>> tb_top.sv
// Directed bench of the converter control block over APB
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic anyChannelEnabled = 1'b0;
  logic sweepDone = 1'b0;
  logic [4:0] sourceEvent = 5'h00;
  logic [31:0] prdata;
  logic [1:0] startDelay;
  logic pready, pslverr, phaseClkGenPowerDown, biasGenPowerDown, currentRefPowerDown;
  logic posRefBufPowerDown, antialiasPowerDown, modulatorPowerDown, gainAmpPowerDown;
  logic sincClkEnable, cubicClkEnable, moduleClkEnable, analogReset, sweepStart;
  logic shortWrapDelay, restoreDefaults, sequencerBusy, combinedIrq, irq;
  logic [10:0] pv;
  int fails = 0;
  int tests_run = 0;
  int starts = 0;
  int rsts = 0;
  int bits[7] = '{10, 9, 7, 5, 3, 2, 1};
  assign pv = {phaseClkGenPowerDown, biasGenPowerDown, currentRefPowerDown, posRefBufPowerDown,
    antialiasPowerDown, modulatorPowerDown, gainAmpPowerDown, sincClkEnable, cubicClkEnable,
    moduleClkEnable, analogReset};
  adc_power_and_command_control u_dut (.*);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (sweepStart === 1'b1)
      starts <= starts + 1;
    if (restoreDefaults === 1'b1)
      rsts <= rsts + 1;
  end
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Holds the request until pready, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle limit here; the watchdog ends a hung access
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("rdata", x, r);
  endtask
  task done;
    sweepDone <= 1'b1;
    @(posedge sys_clk);
    sweepDone <= 1'b0;
    tick(2);
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    chk("pwr", 32'h7F1, pv);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    for (int k = 0; k < 7; k++)
    begin
      wr(8'h00, (32'h1 << bits[k]) | 32'h1);
      tick(2);
      chk("pwr", 11'h7F6 & ~(11'h400 >> k), pv);
      rd(8'h00, (32'h1 << bits[k]) | 32'h1);
    end
    wr(8'h00, 32'h11);
    tick(2);
    chk("pwr", 32'h7FE, pv);
    wr(8'h00, 32'h0000_C001);
    tick(2);
    chk("sdly", 32'h3, startDelay);
    wr(8'h00, 32'h6BE);
    tick(2);
    chk("pwr", 32'h7F1, pv);
    wr(8'h00, 32'h4);
    anyChannelEnabled <= 1'b1;
    tick(2);
    rd(8'h04, 32'h200);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h200);
    anyChannelEnabled <= 1'b0;
    tick(2);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h0800_06BF);
    sourceEvent <= 5'h01;
    tick(1);
    sourceEvent <= 5'h00;
    tick(2);
    chk("cirq", 32'h0, combinedIrq);
    wr(8'h00, 32'h0900_06BF);
    tick(2);
    chk("cirq", 32'h1, combinedIrq);
    rd(8'hE0, 32'h01);
    tick(2);
    chk("cirq", 32'h0, combinedIrq);
    wr(8'h00, 32'h6BF);
    wr(8'hE4, 32'h20);
    wr(8'h04, 32'h1);
    tick(2);
    chk("starts", 32'h1, starts);
    chk("busy", 32'h1, sequencerBusy);
    rd(8'h04, 32'h0);
    rd(8'hE8, 32'h1);
    wr(8'h04, 32'h100);
    tick(2);
    chk("swrap", 32'h1, shortWrapDelay);
    rd(8'h04, 32'h100);
    wr(8'h04, 32'h0);
    tick(2);
    chk("swrap", 32'h0, shortWrapDelay);
    done;
    chk("starts", 32'h2, starts);
    chk("busy", 32'h1, sequencerBusy);
    wr(8'h04, 32'h80);
    rd(8'hE8, 32'h3);
    chk("busy", 32'h1, sequencerBusy);
    done;
    chk("busy", 32'h0, sequencerBusy);
    chk("starts", 32'h2, starts);
    chk("irq", 32'h1, irq);
    rd(8'hE0, 32'h20);
    tick(2);
    chk("irq", 32'h0, irq);
    // Single sweep must not restart on its own
    wr(8'h00, 32'h26BF);
    wr(8'h04, 32'h1);
    tick(2);
    chk("starts", 32'h3, starts);
    done;
    chk("busy", 32'h0, sequencerBusy);
    chk("starts", 32'h3, starts);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    tick(2);
    chk("busy", 32'h0, sequencerBusy);
    wr(8'hE4, 32'h3F);
    wr(8'h00, 32'h6BF);
    wr(8'h04, 32'h8000_0000);
    tick(2);
    chk("rsts", 32'h1, rsts);
    rd(8'h00, 32'h0);
    rd(8'hE4, 32'h0);
    rd(8'h04, 32'h0);
    // Events are not captured while the clock enable is low
    clkEn <= 1'b0;
    sourceEvent <= 5'h02;
    tick(1);
    sourceEvent <= 5'h00;
    clkEn <= 1'b1;
    tick(1);
    rd(8'hE0, 32'h0);
    sourceEvent <= 5'h02;
    tick(1);
    sourceEvent <= 5'h00;
    tick(1);
    rd(8'hE0, 32'h2);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("pslverr", 32'h1, e);
    chk("rdata", 32'h0, r);
    stop_test;
  end
  initial
  begin
    tick(5000);
    fails++;
    stop_test;
  end
endmodule
